// ===== include/ddc_slave_cfg.svh
// constants for the display data channel slave: register offsets, bit positions, counts
// assumes a 20 MHz pclk and APB with 32-bit data, one word per register
//
// Behaviour
// R1 - buffer size bit: clear gives 128 bytes, set gives 256 bytes
// R2 - automatic mode fetches each byte from buffer at pointer and sends it
// R3 - manual mode interrupts processor during each byte so software supplies next
// R4 - serial-bus mode matches A0/A1, or ignores low three address bits when wide
// R5 - transmit-only manual mode sets byte flag on ninth sync clock; software clears
// R6 - transmit-only enable clear ignores sync clock, serial-bus requests still answered
// R7 - mode switch flag set on move to serial-bus mode; software clears it
// R8 - mode bit reads current mode; serial-bus mode sticks until disable or reset
// R9 - unit enabled when transmit-only enable or serial-bus enable is set
// R10 - disabled automatic: no activity, no irq, buffer window goes external
// R11 - enabled automatic: only the unit reaches buffer at FF00h-FFFFh
// R12 - disabled manual: processor reaches buffer for preload, no activity
// R13 - enabled manual: buffer unused, processor reaches it, one irq per byte
// R14 - nine sync clocks of initial sync with data pin released
// R15 - pointer post-increment only in transmit-only region; upper half without it
// R16 - serial-bus mode may hold clock low while software is late
// R17 - reset clears control bits, flags and mode; bit 7 reads zero
// R18 - automatic transmit-only mode advances pointer after each fetched byte
`ifndef DDC_SLAVE_CFG_SVH
`define DDC_SLAVE_CFG_SVH
`define DDC_OFS_CONTROL  12'h000
`define DDC_OFS_POINTER  12'h004
`define DDC_OFS_PORT     12'h008
`define DDC_OFS_SERDATA  12'h00C
`define DDC_OFS_SERCTRL  12'h010
`define DDC_OFS_IRQ_STAT 12'h014
`define DDC_OFS_IRQ_MASK 12'h018
`define DDC_BIT_SIZE     6
`define DDC_BIT_MANUAL   5
`define DDC_BIT_WIDE     4
`define DDC_BIT_BYTEIRQ  3
`define DDC_BIT_TXEN     2
`define DDC_BIT_SWIRQ    1
`define DDC_BIT_MODE     0
`define DDC_BIT_SEREN    6
`define DDC_CTRL_RESET   8'h00
`define DDC_SYNC_CLOCKS  4'h9
`define DDC_BYTE_BITS    4'h9
`define DDC_ADDR_BASE    7'h50
`define DDC_WIN_BASE     8'hFF
`endif

// ===== include/ddc_slave_pkg.sv
// types for the display data channel slave
// assumes the cfg header is included where numbers are needed
package ddc_slave_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SYNC = 2'b01,
		TX_SEND = 2'b10
	} tx_state_t;

	typedef struct packed {
		logic       size_256;
		logic       manual;
		logic       wide;
		logic       tx_en;
	} ctrl_t;

	typedef struct packed {
		logic       req;
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} mem_req_t;
endpackage : ddc_slave_pkg

// ===== rtl/ddc_sync2.sv
// two flip-flop synchroniser for a pin level
// assumes the input is asynchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module ddc_sync2 (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output var  logic dout
);
	logic meta_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 1'b0;
			dout    <= 1'b0;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end
endmodule : ddc_sync2
`default_nettype wire

// ===== rtl/ddc_buffer_ram.sv
// 256 x 8 identification buffer, one port, registered read
// assumes requests come from the arbiter in the top module
`timescale 1ns/100ps
`default_nettype none
module ddc_buffer_ram (
	input  wire logic                  pclk,
	input  wire ddc_slave_pkg::mem_req_t req,
	output var  logic [7:0]            rdata
);
	logic [7:0] mem [0:255];

	always_ff @(posedge pclk) begin
		if (req.req && req.wr) begin
			mem[req.addr] <= req.wdata;
		end
		rdata <= mem[req.addr];
	end
endmodule : ddc_buffer_ram
`default_nettype wire

// ===== rtl/ddc_slave.sv
// display data channel slave: control register, transmit-only link, buffer sharing
// assumes APB master on pclk; sync clock and serial address pins are asynchronous
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`include "ddc_slave_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module ddc_slave (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        vertical_sync_clock,
	input  wire logic        ser_start,
	input  wire logic [6:0]  ser_addr,
	output var  logic        sda_out,
	output var  logic        sda_oe_n,
	output var  logic        scl_hold_oe_n,
	output var  logic        ext_window_sel,
	output var  logic        irq
);
	ddc_slave_pkg::ctrl_t      ctrl_ff;
	ddc_slave_pkg::tx_state_t  tx_state_ff;
	ddc_slave_pkg::tx_state_t  nxt_tx_state;
	ddc_slave_pkg::mem_req_t   mem_req;
	logic       byte_irq_ff, swirq_ff, mode_ff, ser_en_ff;
	logic [7:0] pointer_ff, serdata_ff, shift_ff, mask_ff;
	logic [3:0] cnt_ff;
	logic       vertical_sync_clock_s, vertical_sync_clock_d_ff, start_s, start_d_ff;
	logic       ser_pending_ff;
	logic [6:0] addr_q_ff, addr_s;
	logic       rd_pend_ff;
	logic       port_fetch_ff;

	ddc_sync2 u_vertical_sync_clock (.pclk(pclk), .presetn(presetn), .din(vertical_sync_clock), .dout(vertical_sync_clock_s));
	ddc_sync2 u_start (.pclk(pclk), .presetn(presetn), .din(ser_start), .dout(start_s));

	// address bits are held stable by the far side around its start strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q_ff <= 7'h00;
			addr_s    <= 7'h00;
		end else begin
			addr_q_ff <= ser_addr;
			addr_s    <= addr_q_ff;
		end
	end

	// bus decode
	wire        setup_w   = psel && !penable;
	wire        access_w  = psel && penable;
	// a transfer completes at the edge where pready is seen high, and only there
	wire        done_w    = access_w && pready;
	wire        wr_w      = done_w && pwrite;
	wire        sel_ctrl  = paddr == `DDC_OFS_CONTROL;
	wire        sel_ptr   = paddr == `DDC_OFS_POINTER;
	wire        sel_port  = paddr == `DDC_OFS_PORT;
	wire        sel_sdat  = paddr == `DDC_OFS_SERDATA;
	wire        sel_sctl  = paddr == `DDC_OFS_SERCTRL;
	wire        sel_stat  = paddr == `DDC_OFS_IRQ_STAT;
	wire        sel_mask  = paddr == `DDC_OFS_IRQ_MASK;
	wire        mapped    = sel_ctrl | sel_ptr | sel_port | sel_sdat | sel_sctl | sel_stat
		| sel_mask;
	// R9 unit enable
	wire        enabled   = ctrl_ff.tx_en | ser_en_ff;
	// R10 R11 R12 R13 processor reaches buffer only in manual mode
	wire        cpu_buf   = ctrl_ff.manual;
	// R1 R15 increment only inside the transmit-only region
	wire        in_region = ctrl_ff.size_256 | !pointer_ff[7];
	// buffer read issued at setup so its data is ready one cycle later;
	// a buffer write waits for the completing edge
	wire        port_rd   = setup_w && sel_port && cpu_buf && !pwrite;
	wire        port_wr   = wr_w && sel_port && cpu_buf;
	wire        port_acc  = port_rd | port_wr;

	// R6 sync clock only watched when transmit-only enabled
	wire        vertical_sync_clock_rise = vertical_sync_clock_s && !vertical_sync_clock_d_ff && ctrl_ff.tx_en && !mode_ff;
	wire        start_ev  = start_s && !start_d_ff && ser_en_ff;
	wire [6:0]  addr_base = `DDC_ADDR_BASE;
	// R4 address match
	wire        addr_hit  = ctrl_ff.wide ? (addr_s[6:3] == addr_base[6:3])
		: (addr_s == addr_base);
	// R7 R8 switch on a matched serial-bus start
	wire        go_ser    = start_ev && addr_hit && !mode_ff;
	// R2 R18 automatic fetch at byte boundary
	wire        auto_get  = tx_state_ff == ddc_slave_pkg::TX_SEND && vertical_sync_clock_rise
		&& cnt_ff == `DDC_BYTE_BITS - 4'h1 && !ctrl_ff.manual;
	wire        sync_end  = tx_state_ff == ddc_slave_pkg::TX_SYNC && vertical_sync_clock_rise
		&& cnt_ff == `DDC_SYNC_CLOCKS - 4'h1;
	wire        sync_get  = sync_end && !ctrl_ff.manual;
	wire        fetch     = auto_get | sync_get;
	// R5 R3 ninth clock of each sent byte in manual mode; sync is not a byte
	wire        ninth     = ctrl_ff.manual && vertical_sync_clock_rise
		&& tx_state_ff == ddc_slave_pkg::TX_SEND && cnt_ff == `DDC_BYTE_BITS - 4'h1;
	wire [7:0]  ram_rdata;
	wire [7:0]  stat_vec  = {6'h00, swirq_ff, byte_irq_ff};
	wire [7:0]  ctrl_rd   = {1'b0, ctrl_ff.size_256, ctrl_ff.manual, ctrl_ff.wide,
		byte_irq_ff, ctrl_ff.tx_en, swirq_ff, mode_ff};
	wire [7:0]  clr_vec   = (wr_w && sel_stat) ? pwdata[7:0] : 8'h00;
	wire        clr_byte  = clr_vec[0] | (wr_w && sel_ctrl && !pwdata[`DDC_BIT_BYTEIRQ]);
	wire        clr_sw    = clr_vec[1] | (wr_w && sel_ctrl && !pwdata[`DDC_BIT_SWIRQ]);

	assign mem_req.req   = port_acc | fetch;
	assign mem_req.addr  = fetch ? pointer_ff : pointer_ff;
	assign mem_req.wr    = port_wr;
	assign mem_req.wdata = pwdata[7:0];

	ddc_buffer_ram u_ram (.pclk(pclk), .req(mem_req), .rdata(ram_rdata));

	always_comb begin
		nxt_tx_state = tx_state_ff;
		unique case (tx_state_ff)
			ddc_slave_pkg::TX_IDLE: if (ctrl_ff.tx_en && !mode_ff) begin
				nxt_tx_state = ddc_slave_pkg::TX_SYNC;
			end
			ddc_slave_pkg::TX_SYNC: if (vertical_sync_clock_rise && cnt_ff == `DDC_SYNC_CLOCKS - 4'h1) begin
				nxt_tx_state = ddc_slave_pkg::TX_SEND;
			end
			ddc_slave_pkg::TX_SEND: ;
			default: nxt_tx_state = ddc_slave_pkg::TX_IDLE;
		endcase
		if (!ctrl_ff.tx_en || mode_ff) begin
			nxt_tx_state = ddc_slave_pkg::TX_IDLE;
		end
	end

	// control register; R17 reset clears all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff   <= '0;
			ser_en_ff <= 1'b0;
			mask_ff   <= 8'h00;
		end else begin
			if (wr_w && sel_ctrl) begin
				ctrl_ff <= {pwdata[`DDC_BIT_SIZE], pwdata[`DDC_BIT_MANUAL],
					pwdata[`DDC_BIT_WIDE], pwdata[`DDC_BIT_TXEN]};
			end
			if (wr_w && sel_sctl) begin
				ser_en_ff <= pwdata[`DDC_BIT_SEREN];
			end
			if (wr_w && sel_mask) begin
				mask_ff <= pwdata[7:0];
			end
		end
	end

	// flags: hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_irq_ff <= 1'b0;
			swirq_ff    <= 1'b0;
			mode_ff     <= 1'b0;
		end else begin
			// R5 byte flag
			byte_irq_ff <= ninth | (byte_irq_ff & !clr_byte);
			// R7 switch flag
			swirq_ff    <= go_ser | (swirq_ff & !clr_sw);
			// R8 mode sticks until disabled
			mode_ff     <= enabled & (mode_ff | go_ser);
		end
	end

	// R14 R2 transmit-only shifter and bit counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_ff   <= ddc_slave_pkg::TX_IDLE;
			cnt_ff        <= 4'h0;
			vertical_sync_clock_d_ff     <= 1'b0;
			start_d_ff    <= 1'b0;
			shift_ff      <= 8'hFF;
			port_fetch_ff <= 1'b0;
		end else begin
			vertical_sync_clock_d_ff     <= vertical_sync_clock_s;
			start_d_ff    <= start_s;
			tx_state_ff   <= nxt_tx_state;
			port_fetch_ff <= fetch;
			if (nxt_tx_state == ddc_slave_pkg::TX_IDLE) begin
				cnt_ff <= 4'h0;
			end else if (vertical_sync_clock_rise) begin
				cnt_ff <= (cnt_ff == `DDC_BYTE_BITS - 4'h1) ? 4'h0 : cnt_ff + 4'h1;
				shift_ff <= {shift_ff[6:0], 1'b1};
			end
			// R3 R13 manual bytes come from the serial data register
			if (port_fetch_ff) begin
				shift_ff <= ram_rdata;
			end else if (ninth || (sync_end && ctrl_ff.manual)) begin
				shift_ff <= serdata_ff;
			end
		end
	end

	// R18 R15 pointer and serial data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pointer_ff <= 8'h00;
			serdata_ff <= 8'h00;
		end else begin
			if (wr_w && sel_ptr) begin
				pointer_ff <= pwdata[7:0];
			end else if ((fetch || (done_w && sel_port && cpu_buf)) && in_region) begin
				pointer_ff <= (ctrl_ff.size_256 ? pointer_ff : {1'b0, pointer_ff[6:0]})
					+ 8'h01;
			end
			if (wr_w && sel_sdat) begin
				serdata_ff <= pwdata[7:0];
			end
		end
	end

	// bus answer: buffer port reads take one extra wait state while the buffer read settles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_pend_ff <= 1'b0;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h0000_0000;
		end else begin
			rd_pend_ff <= port_rd;
			pready     <= (setup_w && !port_rd) || rd_pend_ff;
			pslverr    <= setup_w && (!mapped || (sel_port && !cpu_buf));
			if (setup_w) begin
				prdata <= 32'h0000_0000;
				if (!pwrite) begin
					prdata[7:0] <= sel_ctrl ? ctrl_rd : sel_ptr ? pointer_ff
						: sel_sdat ? serdata_ff : sel_sctl ? {1'b0, ser_en_ff, 6'h00}
						: sel_stat ? stat_vec : sel_mask ? mask_ff : 8'h00;
				end
			end else if (rd_pend_ff) begin
				prdata[7:0] <= ram_rdata;
			end
		end
	end

	// pins and interrupt; R16 clock held while a manual byte waits in serial-bus mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_out        <= 1'b1;
			sda_oe_n       <= 1'b1;
			scl_hold_oe_n  <= 1'b1;
			ext_window_sel <= 1'b1;
			irq            <= 1'b0;
		end else begin
			// R14 pin stays released through the whole ninth sync clock;
			// driving starts with the first rise of the first byte
			if (tx_state_ff != ddc_slave_pkg::TX_SEND) begin
				sda_out  <= 1'b1;
				sda_oe_n <= 1'b1;
			end else if (vertical_sync_clock_rise) begin
				sda_out  <= shift_ff[7];
				sda_oe_n <= 1'b0;
			end
			scl_hold_oe_n  <= !(mode_ff && ctrl_ff.manual && byte_irq_ff);
			// R10 window external when disabled and automatic
			ext_window_sel <= !enabled && !ctrl_ff.manual;
			irq            <= |(stat_vec & mask_ff);
		end
	end

	// R5 ninth clock sets flag
	AST_NINTH_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R5
		ninth |=> byte_irq_ff) else $error("byte flag not set on ninth clock");
	// R7 switch flag follows switch
	AST_SWITCH_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R7
		go_ser |=> swirq_ff && mode_ff) else $error("switch flag or mode missing");
	// R8 mode held while enabled
	AST_MODE_STICK: assert property (@(posedge pclk) disable iff (!presetn) // R8
		mode_ff && enabled |=> mode_ff) else $error("mode dropped while enabled");
	// R10 window external
	AST_WINDOW: assert property (@(posedge pclk) disable iff (!presetn) // R10
		!enabled && !ctrl_ff.manual |=> ext_window_sel) else $error("window not external");
	// R11 processor blocked in automatic mode
	AST_NO_CPU: assert property (@(posedge pclk) disable iff (!presetn) // R11
		!ctrl_ff.manual |-> !port_acc) else $error("processor reached buffer");
	// R14 pin released in sync
	AST_SYNC_HIZ: assert property (@(posedge pclk) disable iff (!presetn) // R14
		tx_state_ff == ddc_slave_pkg::TX_SYNC ##1 tx_state_ff == ddc_slave_pkg::TX_SYNC
		|-> sda_oe_n) else $error("data pin driven during sync");
	// R14 pin driven only after a sending cycle
	AST_DRIVE_SEND: assert property (@(posedge pclk) disable iff (!presetn) // R14
		!sda_oe_n |-> $past(tx_state_ff) == ddc_slave_pkg::TX_SEND)
		else $error("data pin driven outside byte sending");
	// R6 link idle when transmit-only is disabled
	AST_IGNORE_VERTICAL_SYNC_CLOCK: assert property (@(posedge pclk) disable iff (!presetn) // R6
		!ctrl_ff.tx_en |=> tx_state_ff == ddc_slave_pkg::TX_IDLE)
		else $error("link busy while transmit-only disabled");
	// R13 buffer read answered after one extra wait
	AST_PORT_WAIT: assert property (@(posedge pclk) disable iff (!presetn) // R13
		port_rd |=> !pready ##1 pready) else $error("buffer read answer out of step");
	// R18 pointer advances after fetch
	AST_PTR_INC: assert property (@(posedge pclk) disable iff (!presetn) // R18
		fetch && in_region && !(wr_w && sel_ptr) |=> pointer_ff != $past(pointer_ff))
		else $error("pointer did not advance");
	// R17 bit seven reads zero
	AST_BIT7: assert property (@(posedge pclk) disable iff (!presetn) // R17
		!ctrl_rd[7]) else $error("reserved bit set");
endmodule : ddc_slave
`default_nettype wire

// ===== tb/ddc_host_model.sv
// host side of the display link: sync clock source, serial start source, data pin sampler
// assumes the bench calls its tasks by hierarchical name, one task at a time
`timescale 1ns/100ps
`default_nettype none
module ddc_host_model (
	output var  logic       vsync,
	output var  logic       ser_start,
	output var  logic [6:0] ser_addr,
	input  wire logic       sda_out,
	input  wire logic       sda_oe_n
);
	logic [8:0] bits;
	logic       released;

	initial begin
		vsync = 1'b0;
		ser_start = 1'b0;
		bits = 9'h000;
		released = 1'b1;
	end

	// n sync clocks, as many as the caller asks for
	// the clock stands low between calls; the pin is sampled half a period after each rise
	task automatic clocks(input int n);
		released = 1'b1;
		for (int i = 0; i < n; i++) begin
			#200 vsync = 1'b1;
			#200 vsync = 1'b0;
			bits = {bits[7:0], sda_out};
			released = released & sda_oe_n;
		end
	endtask : clocks

	// address with start
	// the address is turned round once the start is over, so a stale value never matches
	task automatic start(input logic [6:0] a);
		ser_addr = a;
		#130 ser_start = 1'b1;
		#400 ser_start = 1'b0;
		#100 ser_addr = ~a;
	endtask : start
endmodule : ddc_host_model
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the display data channel slave, driven over APB
// assumes the slave answers every transfer and the host model drives the link pins
`include "ddc_slave_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam logic [31:0] man_b  = 32'h1 << `DDC_BIT_MANUAL;
	localparam logic [31:0] size_b = 32'h1 << `DDC_BIT_SIZE;
	localparam logic [31:0] wide_b = 32'h1 << `DDC_BIT_WIDE;
	localparam logic [31:0] txen_b = 32'h1 << `DDC_BIT_TXEN;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, vsync, ser_start, sda_out, sda_oe_n, scl_n, ext_sel, irq;
	logic [6:0]  ser_addr;
	int          fails, checks;

	ddc_slave DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .vertical_sync_clock(vsync), .ser_start(ser_start),
		.ser_addr(ser_addr), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_hold_oe_n(scl_n),
		.ext_window_sel(ext_sel), .irq(irq));
	ddc_host_model host (.vsync(vsync), .ser_start(ser_start), .ser_addr(ser_addr),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk

	// request held from setup until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			chk(32'h0, 32'h1, "no pready");
			end_of_test();
		end
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe = 1'b0);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		chk({31'h0, e}, {31'h0, xe}, "write error flag");
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe = 1'b0);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x, "read data");
		chk({31'h0, e}, {31'h0, xe}, "read error flag");
	endtask : rd

	task automatic pins(input logic xirq, input logic xext);
		repeat (3) @(posedge pclk);
		// clock hold stays released in every state these scenarios reach
		chk({29'h0, irq, ext_sel, scl_n}, {29'h0, xirq, xext, 1'b1}, "irq window hold");
	endtask : pins

	initial begin
		{fails, checks} = 0;
		{psel, penable} = '0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(`DDC_OFS_CONTROL, 32'h0);
		pins(1'b0, 1'b1);
		wr(`DDC_OFS_CONTROL, 32'hF4);
		rd(`DDC_OFS_CONTROL, 32'h74);
		wr(`DDC_OFS_CONTROL, 32'h0);
		rd(`DDC_OFS_PORT, 32'h0, 1'b1);
		rd(12'h01C, 32'h0, 1'b1);
		wr(`DDC_OFS_IRQ_MASK, 32'h3);
		wr(`DDC_OFS_CONTROL, man_b);
		pins(1'b0, 1'b0);
		wr(`DDC_OFS_POINTER, 32'h0);
		wr(`DDC_OFS_PORT, 32'hA5);
		wr(`DDC_OFS_PORT, 32'h3C);
		rd(`DDC_OFS_POINTER, 32'h2);
		wr(`DDC_OFS_POINTER, 32'h0);
		rd(`DDC_OFS_PORT, 32'hA5);
		rd(`DDC_OFS_PORT, 32'h3C);
		wr(`DDC_OFS_POINTER, 32'hC8);
		wr(`DDC_OFS_PORT, 32'h5A);
		rd(`DDC_OFS_POINTER, 32'hC8);
		wr(`DDC_OFS_CONTROL, man_b | size_b);
		rd(`DDC_OFS_PORT, 32'h5A);
		rd(`DDC_OFS_POINTER, 32'hC9);
		host.clocks(18);
		rd(`DDC_OFS_IRQ_STAT, 32'h0);
		// automatic transmit-only link from the preloaded bytes
		wr(`DDC_OFS_CONTROL, 32'h0);
		wr(`DDC_OFS_POINTER, 32'h0);
		wr(`DDC_OFS_CONTROL, txen_b);
		pins(1'b0, 1'b0);
		rd(`DDC_OFS_PORT, 32'h0, 1'b1);
		host.clocks(9);
		chk({31'h0, host.released}, 32'h1, "data pin during sync");
		host.clocks(9);
		chk({24'h0, host.bits[8:1]}, 32'hA5, "first byte");
		host.clocks(9);
		chk({24'h0, host.bits[8:1]}, 32'h3C, "second byte");
		rd(`DDC_OFS_IRQ_STAT, 32'h0);
		// manual transmit-only link, one flag per byte
		wr(`DDC_OFS_CONTROL, 32'h0);
		wr(`DDC_OFS_SERDATA, 32'h96);
		wr(`DDC_OFS_CONTROL, man_b | txen_b);
		host.clocks(17);
		rd(`DDC_OFS_IRQ_STAT, 32'h0);
		host.clocks(1);
		rd(`DDC_OFS_IRQ_STAT, 32'h1);
		rd(`DDC_OFS_CONTROL, 32'h2C);
		pins(1'b1, 1'b0);
		wr(`DDC_OFS_IRQ_MASK, 32'h2);
		pins(1'b0, 1'b0);
		wr(`DDC_OFS_IRQ_MASK, 32'h3);
		wr(`DDC_OFS_IRQ_STAT, 32'h1);
		pins(1'b0, 1'b0);
		rd(`DDC_OFS_IRQ_STAT, 32'h0);
		// serial-bus address match and mode switch
		wr(`DDC_OFS_CONTROL, 32'h0);
		wr(`DDC_OFS_SERCTRL, 32'h40);
		pins(1'b0, 1'b0);
		host.start(7'h51);
		rd(`DDC_OFS_CONTROL, 32'h0);
		wr(`DDC_OFS_CONTROL, wide_b);
		host.start(7'h51);
		rd(`DDC_OFS_CONTROL, 32'h13);
		pins(1'b1, 1'b0);
		wr(`DDC_OFS_IRQ_STAT, 32'h2);
		rd(`DDC_OFS_CONTROL, 32'h11);
		wr(`DDC_OFS_CONTROL, 32'h0);
		host.start(7'h50);
		rd(`DDC_OFS_CONTROL, 32'h1);
		wr(`DDC_OFS_SERCTRL, 32'h0);
		rd(`DDC_OFS_CONTROL, 32'h0);
		pins(1'b0, 1'b1);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
